// *** core/cmya_pkg.sv ***
// package: register map, field layout and reset values for month/year calendar and alarm match
package cmya_pkg;
    localparam logic [7:0] OFS_MONTH = 8'h0D;
    localparam logic [7:0] OFS_YEAR = 8'h0E;
    localparam logic [7:0] OFS_ALARM_SEC = 8'h10;
    localparam int MONTH_MSB = 4;
    localparam int YEAR_MSB = 6;
    localparam int ALARM_EN_BIT = 7;
    localparam logic [4:0] MONTH_RST = 5'h01;
    localparam logic [4:0] MONTH_JAN = 5'h01;
    localparam logic [4:0] MONTH_FEB = 5'h02;
    localparam logic [4:0] MONTH_SEP = 5'h09;
    localparam logic [4:0] MONTH_OCT = 5'h10;
    localparam logic [4:0] MONTH_DEC = 5'h12;
    localparam logic [6:0] YEAR_RST = 7'h00;
    localparam logic [6:0] YEAR_MAX = 7'h79;
    localparam logic [7:0] ALARM_SEC_RST = 8'h00;
endpackage : cmya_pkg

// *** core/cmya_bcd_inc.sv ***
// module: BCD two-digit incrementer with wrap
`timescale 1ns/1ns
`default_nettype none
module cmya_bcd_inc #(
    parameter int W = 7
) (
    // value in
    input wire logic [W-1:0] val_i,
    // wrap value and restart value
    input wire logic [W-1:0] max_i,
    input wire logic [W-1:0] min_i,
    // result
    output logic [W-1:0] inc_o,
    output logic wrap_o
);
    // elaboration check: full units digit plus at least one tens bit, two digits at most
    if (W < 5 || W > 8) begin : g_bad_width
        $error("cmya_bcd_inc: width out of range");
    end
    logic [7:0] v;
    logic [7:0] r;
    always_comb begin
        v = 8'h00;
        v[W-1:0] = val_i;
        if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
    end
    assign wrap_o = (val_i == max_i);
    assign inc_o = wrap_o ? min_i : r[W-1:0];
endmodule : cmya_bcd_inc
`default_nettype wire

// *** core/cmya_calendar.sv ***
// module: month/year calendar counters with alarm match and interrupt
// Function
// [RQ1] month held as BCD 1..12 in bits 4:0
// [RQ2] February gets day 29 when year divisible by four
// [RQ3] year held as BCD 0..79 in bits 6:0
// [RQ4] enabled valid alarm fields compared with current counters
// [RQ5] flag set on first all-match when irq enabled
// [RQ6] flag with irq enable drives interrupt pin
// [RQ7] disabled alarm fields ignored in match decision
// [RQ8] alarm seconds: bit 7 enable, 6:0 BCD second
// [RQ9] month advances past last day, December wraps, year increments
`timescale 1ns/1ns
`default_nettype none
module cmya_calendar (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // day counter interface
    input wire logic [5:0] day_i,
    input wire logic day_tick_i,
    input wire logic [6:0] second_i,
    output logic last_day_o,
    // alarm fields from other alarm registers: match and enable
    input wire logic other_fields_match_i,
    // control bits
    input wire logic alarm_irq_enable_i,
    input wire logic alarm_flag_clear_i,
    output logic alarm_match_flag_o,
    output logic irq_n_o
);
    ////////////////////////////////////////////////////////////////
    // registers
    logic [4:0] month_r;
    logic [6:0] year_r;
    logic [7:0] alarm_sec_r;
    logic flag_r;
    logic match_d_r;
    logic [4:0] month_nxt;
    logic [6:0] year_nxt;
    logic [4:0] month_inc;
    logic [6:0] year_inc;
    logic month_wrap;
    logic year_wrap;
    logic [5:0] last_day;
    logic leap;
    logic all_match;
    logic wr_month;
    logic wr_year;
    logic wr_alarm;

    assign wr_month = reg_wr_i && (reg_addr_i == cmya_pkg::OFS_MONTH);
    assign wr_year = reg_wr_i && (reg_addr_i == cmya_pkg::OFS_YEAR);
    assign wr_alarm = reg_wr_i && (reg_addr_i == cmya_pkg::OFS_ALARM_SEC);

    ////////////////////////////////////////////////////////////////
    // month length and leap year
    // BCD divisible by four: tens even with units 0,4,8; tens odd with units 2,6
    assign leap = year_r[4] ? (year_r[3:0] == 4'h2 || year_r[3:0] == 4'h6)
                            : (year_r[1:0] == 2'b00); // [RQ2]
    always_comb begin
        unique case (month_r)
            cmya_pkg::MONTH_FEB: last_day = leap ? 6'h29 : 6'h28; // [RQ2]
            5'h04, 5'h06, cmya_pkg::MONTH_SEP, 5'h11: last_day = 6'h30;
            default: last_day = 6'h31;
        endcase
    end
    assign last_day_o = (day_i == last_day);

    ////////////////////////////////////////////////////////////////
    // incrementers
    cmya_bcd_inc #(.W(5)) u_month_inc (
        .val_i(month_r),
        .max_i(cmya_pkg::MONTH_DEC),
        .min_i(cmya_pkg::MONTH_JAN),
        .inc_o(month_inc),
        .wrap_o(month_wrap)
    );
    cmya_bcd_inc #(.W(7)) u_year_inc (
        .val_i(year_r),
        .max_i(cmya_pkg::YEAR_MAX),
        .min_i(cmya_pkg::YEAR_RST),
        .inc_o(year_inc),
        .wrap_o(year_wrap)
    );

    ////////////////////////////////////////////////////////////////
    // month and year counters
    always_comb begin
        month_nxt = month_r;
        year_nxt = year_r;
        if (day_tick_i && last_day_o) begin
            month_nxt = month_inc; // [RQ9]
            if (month_wrap) begin
                year_nxt = year_inc; // [RQ9]
            end
        end
        if (wr_month) begin
            month_nxt = reg_wdata_i[cmya_pkg::MONTH_MSB:0]; // [RQ1]
        end
        if (wr_year) begin
            year_nxt = reg_wdata_i[cmya_pkg::YEAR_MSB:0]; // [RQ3]
        end
    end
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            month_r <= cmya_pkg::MONTH_RST;
            year_r <= cmya_pkg::YEAR_RST;
        end else begin
            month_r <= month_nxt;
            year_r <= year_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // alarm seconds register
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alarm_sec_r <= cmya_pkg::ALARM_SEC_RST;
        end else if (wr_alarm) begin
            alarm_sec_r <= reg_wdata_i; // [RQ8]
        end
    end

    ////////////////////////////////////////////////////////////////
    // alarm match
    assign all_match = other_fields_match_i
        && (!alarm_sec_r[cmya_pkg::ALARM_EN_BIT] || alarm_sec_r[6:0] == second_i); // [RQ4] [RQ7]
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            match_d_r <= 1'b0;
        end else begin
            match_d_r <= all_match;
        end
    end
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_r <= 1'b0;
        end else if (all_match && !match_d_r && alarm_irq_enable_i) begin
            flag_r <= 1'b1; // [RQ5]
        end else if (alarm_flag_clear_i) begin
            flag_r <= 1'b0;
        end
    end
    assign alarm_match_flag_o = flag_r;
    assign irq_n_o = !(flag_r && alarm_irq_enable_i); // [RQ6]

    ////////////////////////////////////////////////////////////////
    // read data
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            unique case (reg_addr_i)
                cmya_pkg::OFS_MONTH: reg_rdata_o <= {3'b000, month_r}; // [RQ1]
                cmya_pkg::OFS_YEAR: reg_rdata_o <= {1'b0, year_r}; // [RQ3]
                cmya_pkg::OFS_ALARM_SEC: reg_rdata_o <= alarm_sec_r; // [RQ8]
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    property p_flag_rise;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (all_match && !match_d_r && alarm_irq_enable_i) |=> flag_r;
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag not set on match"); // [RQ5]
    property p_flag_cause;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(flag_r) |-> $past(all_match) && !$past(match_d_r);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag set without match"); // [RQ4]
    property p_irq;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (flag_r && alarm_irq_enable_i) |-> !irq_n_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not driven"); // [RQ6]
    property p_sec_dis;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (!alarm_sec_r[7] && other_fields_match_i) |-> all_match;
    endproperty
    a_sec_dis: assert property (p_sec_dis) else $error("disabled field blocked"); // [RQ7]
    property p_month_range;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (day_tick_i && last_day_o && !wr_month && month_r == cmya_pkg::MONTH_DEC) |=> month_r == 5'h01;
    endproperty
    a_month_range: assert property (p_month_range) else $error("december wrap wrong"); // [RQ9]
    property p_year_inc;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (day_tick_i && last_day_o && !wr_year && month_r == cmya_pkg::MONTH_DEC && year_r == 7'h19)
        |=> year_r == 7'h20;
    endproperty
    a_year_inc: assert property (p_year_inc) else $error("year increment wrong"); // [RQ3]
    property p_leap;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (month_r == cmya_pkg::MONTH_FEB && (year_r == 7'h00 || year_r == 7'h12)) |-> last_day == 6'h29;
    endproperty
    a_leap: assert property (p_leap) else $error("leap february wrong"); // [RQ2]
    property p_nonleap;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (month_r == cmya_pkg::MONTH_FEB && year_r == 7'h13) |-> last_day == 6'h28;
    endproperty
    a_nonleap: assert property (p_nonleap) else $error("non-leap february wrong"); // [RQ2]
    property p_month_wr;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        wr_month |=> month_r == $past(reg_wdata_i[4:0]);
    endproperty
    a_month_wr: assert property (p_month_wr) else $error("month write lost"); // [RQ1]
    property p_alarm_wr;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        wr_alarm |=> alarm_sec_r == $past(reg_wdata_i);
    endproperty
    a_alarm_wr: assert property (p_alarm_wr) else $error("alarm write lost"); // [RQ8]
endmodule : cmya_calendar
`default_nettype wire

// *** test/cmya_host_model.sv ***
// host model: register writes and reads over the block's register port
`timescale 1ns/1ns
`default_nettype none
module cmya_host_model (
    // clock
    input wire logic clk_sys_i,
    // register port
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // one strobe per byte, held over one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask : wr
    // read data comes one cycle after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        reg_addr_o = a;
        @(negedge clk_sys_i);
        d = reg_rdata_i;
    endtask : rd
endmodule : cmya_host_model
`default_nettype wire

// *** test/cmya_calendar_tb.sv ***
// testbench: month/year counters, leap handling and alarm match
`timescale 1ns/1ns
`default_nettype none
module cmya_calendar_tb;
    logic clk_sys_i, nrst_i, reg_wr, tick, other, irq_en, clr, last_day, flag, irq_n;
    logic [7:0] addr, wdata, rdata, v;
    logic [6:0] sec;
    logic [5:0] day;
    int n_mismatch = 0;
    int n_checks = 0;
    cmya_host_model i_host (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wr_o(reg_wr),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata));
    cmya_calendar i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wr_i(reg_wr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .day_i(day), .day_tick_i(tick), .second_i(sec),
        .last_day_o(last_day), .other_fields_match_i(other), .alarm_irq_enable_i(irq_en),
        .alarm_flag_clear_i(clr), .alarm_match_flag_o(flag), .irq_n_o(irq_n));
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, v);
        chk(v, exp);
    endtask : rdchk
    // match input rises once, flag and pin then compared
    task automatic rise(input logic [1:0] exp);
        @(negedge clk_sys_i);
        other = 1'b0;
        @(negedge clk_sys_i);
        other = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk({6'h00, flag, irq_n}, {6'h00, exp});
        other = 1'b0;
    endtask : rise
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_fields;
        rdchk(cmya_pkg::OFS_MONTH, 8'h01);
        rdchk(cmya_pkg::OFS_YEAR, 8'h00);
        rdchk(cmya_pkg::OFS_ALARM_SEC, 8'h00);
        i_host.wr(8'h20, 8'h55);
        rdchk(8'h20, 8'h00);
        i_host.wr(cmya_pkg::OFS_MONTH, 8'hF2);
        rdchk(cmya_pkg::OFS_MONTH, 8'h12);
        i_host.wr(cmya_pkg::OFS_YEAR, 8'hFF);
        rdchk(cmya_pkg::OFS_YEAR, 8'h7F);
    endtask : t_reset_and_fields
    task automatic t_leap;
        logic [7:0] yr [7] = '{8'h00, 8'h01, 8'h01, 8'h12, 8'h10, 8'h10, 8'h13};
        logic [5:0] dy [7] = '{6'h29, 6'h28, 6'h29, 6'h29, 6'h28, 6'h29, 6'h28};
        logic ex [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        i_host.wr(cmya_pkg::OFS_MONTH, 8'h02);
        for (int i = 0; i < 7; i++) begin
            i_host.wr(cmya_pkg::OFS_YEAR, yr[i]);
            day = dy[i];
            #1;
            chk({7'h00, last_day}, {7'h00, ex[i]});
        end
    endtask : t_leap
    task automatic t_roll(input logic [7:0] m, input logic [7:0] y, input logic [5:0] d,
        input logic [7:0] em, input logic [7:0] ey);
        i_host.wr(cmya_pkg::OFS_MONTH, m);
        i_host.wr(cmya_pkg::OFS_YEAR, y);
        @(negedge clk_sys_i);
        day = d;
        tick = 1'b1;
        @(negedge clk_sys_i);
        tick = 1'b0;
        rdchk(cmya_pkg::OFS_MONTH, em);
        rdchk(cmya_pkg::OFS_YEAR, ey);
    endtask : t_roll
    task automatic t_alarm;
        sec = 7'h25;
        i_host.wr(cmya_pkg::OFS_ALARM_SEC, 8'hA4);
        rise(2'b01);
        i_host.wr(cmya_pkg::OFS_ALARM_SEC, 8'hA5);
        rdchk(cmya_pkg::OFS_ALARM_SEC, 8'hA5);
        rise(2'b10);
        @(negedge clk_sys_i);
        clr = 1'b1;
        @(negedge clk_sys_i);
        clr = 1'b0;
        irq_en = 1'b0;
        rise(2'b01);
        irq_en = 1'b1;
        i_host.wr(cmya_pkg::OFS_ALARM_SEC, 8'h24);
        rise(2'b10);
        @(negedge clk_sys_i);
        other = 1'b1;
        clr = 1'b1;
        @(negedge clk_sys_i);
        other = 1'b0;
        clr = 1'b0;
        chk({6'h00, flag, irq_n}, 8'h02);
    endtask : t_alarm
    // reset in mid-run; month counter, alarm and flag then checked against their reset values
    task automatic t_mid_reset;
        @(negedge clk_sys_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        chk({6'h00, flag, irq_n}, 8'h01);
        rdchk(cmya_pkg::OFS_MONTH, 8'h01);
        rdchk(cmya_pkg::OFS_ALARM_SEC, 8'h00);
    endtask : t_mid_reset
    ////////////////////////////////////////////////////////////////////////
    initial begin
        nrst_i = 1'b0;
        tick = 1'b0;
        other = 1'b0;
        irq_en = 1'b1;
        clr = 1'b0;
        sec = 7'h00;
        day = 6'h01;
        repeat (12) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        t_reset_and_fields();
        t_leap();
        t_roll(8'h12, 8'h79, 6'h31, 8'h01, 8'h00);
        t_roll(8'h12, 8'h19, 6'h31, 8'h01, 8'h20);
        t_roll(8'h09, 8'h05, 6'h30, 8'h10, 8'h05);
        t_alarm();
        t_mid_reset();
        report_and_stop();
    end
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end
endmodule : cmya_calendar_tb
`default_nettype wire
